// ===== src/slc_top.v
// Purpose: Load on/off, short simulation and front panel lock control
// Assumes: Keys debounced, all inputs synchronous to clock
// Notes: Setpoint override is muxed here; analog loop lies outside
// Function
// - Load key press flips load state
// - Load request also from remote, external
// - Mode/range change drops load unless disabled
// - Short drives mode-specific extreme setpoint
// - External short signal while shorted
// - Short key lamp and icon while shorted
// - Short from off turns load on, off
// - Short from on restores prior setpoint
// - Guard allows short only while on
// - Short key toggle or hold, default toggle
// - Hold mode shorts only while pressed
// - Short disable ignores key and settings
// - Guard setting locked while short disabled
// - Shift then clear toggles panel lock
// - Lock rejects key changes other than load-off and ending a short, shows icon
// - Load-off key works while locked
// - Mode/range selector, change while on drops load if its drop setting is on
`timescale 1ns/100ps
`include "slc_regs.vh"
module slc_top #(
  parameter SP_W = `SLC_SP_W // Setpoint width
) (
  input wire clock, // 20 MHz system clock
  input wire rst, // Synchronous reset, active high
  input wire key_load, // Load on/off key level
  input wire key_short, // Short key level
  input wire key_shift, // Shift key level
  input wire key_clear, // Clear key level
  input wire panel_sel_we, // Panel mode/range change strobe
  input wire [1:0] panel_mode, // Panel mode selection
  input wire [1:0] panel_range, // Panel range selection
  input wire [SP_W-1:0] panel_setp, // Panel setpoint value
  input wire panel_setp_we, // Panel/wheel setpoint strobe
  input wire remote_load_on, // Remote load-on pulse
  input wire ext_load_on, // External control load-on pulse
  input wire [`SLC_AW-1:0] reg_addr, // Register byte address
  input wire [`SLC_DW-1:0] reg_wdata, // Register write data
  input wire reg_wr, // Register write strobe
  input wire reg_rd, // Register read strobe
  output reg [`SLC_DW-1:0] reg_rdata, // Read data, cycle after strobe
  output reg load_on_q, // Load sinking, also key/panel lamp
  output reg short_q, // Short active, key lamp and icon
  output reg ext_short_q, // External short signal
  output reg lock_q, // Panel lock icon
  output reg [1:0] mode_q, // Operating mode
  output reg [1:0] range_q, // Current/voltage range
  output reg [SP_W-1:0] setp_out_q // Setpoint to analog path
);
  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_ON = 2'h1;
  localparam [1:0] ST_SHORT_FROM_OFF = 2'h2;
  localparam [1:0] ST_SHORT_FROM_ON = 2'h3;

  wire p_load;
  wire p_short;
  wire p_clear;
  wire p_short_rel;
  reg shift_armed_q;
  reg key_short_q;
  reg [4:0] cfg_q;
  reg [SP_W-1:0] setp_q;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg wr_load;
  reg wr_short;
  reg sel_chg;
  reg [1:0] mode_d;
  reg [1:0] range_d;

  // Extreme setpoint chosen per mode during a short
  function [SP_W-1:0] short_setp;
    input [1:0] mode;
    begin
      case (mode)
        `SLC_MODE_CC: short_setp = {SP_W{1'b1}};
        `SLC_MODE_CR: short_setp = {SP_W{1'b0}};
        `SLC_MODE_CV: short_setp = {SP_W{1'b0}};
        default: short_setp = {SP_W{1'b1}};
      endcase
    end
  endfunction

  // Register write decode, shared by every writable register
  function wr_hit;
    input we;
    input [`SLC_AW-1:0] addr;
    input [`SLC_AW-1:0] offs;
    begin
      wr_hit = we && (addr == offs);
    end
  endfunction

  // Key press pulse generators, one per key that acts on a press
  wire [2:0] key_lvl = {key_clear, key_short, key_load};
  wire [2:0] key_pls;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_key
      slc_edge i_slc_edge (
        .clock(clock),
        .rst(rst),
        .level(key_lvl[gi]),
        .pulse(key_pls[gi])
      );
    end
  endgenerate
  assign p_load = key_pls[0];
  assign p_short = key_pls[1];
  assign p_clear = key_pls[2];

  // Hold mode ends the short on key release
  assign p_short_rel = key_short_q & ~key_short;

  // Config bit aliases
  wire en_short = cfg_q[`SLC_CFG_SHORT_EN];
  wire off_mode = cfg_q[`SLC_CFG_OFF_MODE];
  wire off_range = cfg_q[`SLC_CFG_OFF_RANGE];
  wire guard = cfg_q[`SLC_CFG_GUARD] & en_short;
  wire hold = cfg_q[`SLC_CFG_HOLD] & en_short;
  wire shorted = st_q[1];

  // Mode and range selection from panel or software
  always @* begin
    mode_d = mode_q;
    range_d = range_q;
    if (wr_hit(reg_wr, reg_addr, `SLC_REG_SETP)) begin
      mode_d = reg_wdata[17:16];
      range_d = reg_wdata[19:18];
    end else if (panel_sel_we && !lock_q) begin
      mode_d = panel_mode;
      range_d = panel_range;
    end
    // Only a mode change with its setting on, or range likewise, drops load
    sel_chg = ((mode_d != mode_q) && off_mode) || ((range_d != range_q) && off_range);
  end

  // Load and short state machine
  always @* begin
    wr_load = wr_hit(reg_wr, reg_addr, `SLC_REG_CTRL) && reg_wdata[`SLC_CTRL_LOAD_REQ];
    wr_short = wr_hit(reg_wr, reg_addr, `SLC_REG_CTRL) && reg_wdata[`SLC_CTRL_SHORT_REQ];
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        if ((p_load && !lock_q) || remote_load_on || ext_load_on || wr_load)
          st_d = ST_ON;
        else if ((p_short && !lock_q || wr_short) && en_short && !guard)
          st_d = ST_SHORT_FROM_OFF;
      end
      ST_ON: begin
        if (p_load || wr_load)
          st_d = ST_OFF;
        else if ((p_short && !lock_q || wr_short) && en_short)
          st_d = ST_SHORT_FROM_ON;
      end
      default: begin
        // Lock does not block ending a short or the load-off key
        if (p_load || wr_load)
          st_d = ST_OFF;
        else if (!en_short || (hold ? p_short_rel : (p_short || wr_short)))
          st_d = (st_q == ST_SHORT_FROM_ON) ? ST_ON : ST_OFF;
      end
    endcase
    if (sel_chg && st_q != ST_OFF)
      st_d = ST_OFF;
  end

  // State, config, lock and setpoint registers
  always @(posedge clock) begin
    if (rst) begin
      st_q <= ST_OFF;
      cfg_q <= `SLC_CFG_RESET;
      lock_q <= 1'b0;
      shift_armed_q <= 1'b0;
      key_short_q <= 1'b0;
      mode_q <= `SLC_MODE_CC;
      range_q <= 2'h0;
      setp_q <= {SP_W{1'b0}};
    end else begin
      st_q <= st_d;
      key_short_q <= key_short;
      mode_q <= mode_d;
      range_q <= range_d;
      // Shift arms, clear toggles lock; other keys disarm
      if (p_clear && (shift_armed_q || key_shift))
        lock_q <= ~lock_q;
      if (key_shift)
        shift_armed_q <= 1'b1;
      else if (p_clear || p_load || p_short)
        shift_armed_q <= 1'b0;
      if (wr_hit(reg_wr, reg_addr, `SLC_REG_CFG)) begin
        cfg_q[`SLC_CFG_OFF_MODE] <= reg_wdata[`SLC_CFG_OFF_MODE];
        cfg_q[`SLC_CFG_OFF_RANGE] <= reg_wdata[`SLC_CFG_OFF_RANGE];
        cfg_q[`SLC_CFG_HOLD] <= reg_wdata[`SLC_CFG_HOLD];
        cfg_q[`SLC_CFG_SHORT_EN] <= reg_wdata[`SLC_CFG_SHORT_EN];
        // Guard frozen while short feature is off
        if (en_short)
          cfg_q[`SLC_CFG_GUARD] <= reg_wdata[`SLC_CFG_GUARD];
      end
      // Stored setpoint untouched by the short, so it comes back after
      if (wr_hit(reg_wr, reg_addr, `SLC_REG_SETP))
        setp_q <= reg_wdata[SP_W-1:0];
      else if (panel_setp_we && !lock_q)
        setp_q <= panel_setp;
    end
  end

  // Registered outputs
  always @(posedge clock) begin
    if (rst) begin
      load_on_q <= 1'b0;
      short_q <= 1'b0;
      ext_short_q <= 1'b0;
      setp_out_q <= {SP_W{1'b0}};
    end else begin
      load_on_q <= st_d != ST_OFF;
      short_q <= st_d[1];
      ext_short_q <= st_d[1];
      setp_out_q <= st_d[1] ? short_setp(mode_d) : setp_q;
    end
  end

  // Register read, data in the cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= {`SLC_DW{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `SLC_REG_CFG: reg_rdata <= {27'h0000000, cfg_q};
        `SLC_REG_STAT: reg_rdata <= {29'h0000000, lock_q, shorted, st_q != ST_OFF};
        `SLC_REG_SETP: reg_rdata <= {12'h000, range_q, mode_q, setp_q};
        default: reg_rdata <= {`SLC_DW{1'b0}};
      endcase
    end else begin
      reg_rdata <= {`SLC_DW{1'b0}};
    end
  end
endmodule

// ===== src/slc_regs.vh
// Purpose: Constants for the load on/off, short and panel lock control block
// Assumes: Register port with one-cycle read latency, 32-bit data
// Notes: Offsets are byte addresses, one word per register
`ifndef SLC_REGS_VH
`define SLC_REGS_VH
`define SLC_AW 4
`define SLC_DW 32
// Register offsets
`define SLC_REG_CTRL 4'h0
`define SLC_REG_CFG 4'h4
`define SLC_REG_STAT 4'h8
`define SLC_REG_SETP 4'hC
// Control register fields (write pulses)
`define SLC_CTRL_LOAD_REQ 0
`define SLC_CTRL_SHORT_REQ 1
// Configuration register fields
`define SLC_CFG_OFF_MODE 0
`define SLC_CFG_OFF_RANGE 1
`define SLC_CFG_GUARD 2
`define SLC_CFG_HOLD 3
`define SLC_CFG_SHORT_EN 4
`define SLC_CFG_RESET 5'h13
// Status register fields
`define SLC_STAT_LOAD 0
`define SLC_STAT_SHORT 1
`define SLC_STAT_LOCK 2
// Operating modes
`define SLC_MODE_CC 2'h0
`define SLC_MODE_CR 2'h1
`define SLC_MODE_CV 2'h2
`define SLC_MODE_CP 2'h3
`define SLC_SP_W 16
`define SLC_SP_MAX 16'hFFFF
`define SLC_SP_MIN 16'h0000
`endif

// ===== src/slc_edge.v
// Purpose: Turns a debounced key level into a one-cycle press pulse
// Assumes: Key level already debounced and synchronous to clock
// Notes: Pulse appears the cycle after the rising level is seen
`timescale 1ns/100ps
module slc_edge (
  input wire clock, // System clock
  input wire rst, // Synchronous reset, active high
  input wire level, // Debounced key level
  output reg pulse // One-cycle press event
);
  reg level_q;

  // Rising edge detect, one event per press
  always @(posedge clock) begin
    if (rst) begin
      level_q <= 1'b0;
      pulse <= 1'b0;
    end else begin
      level_q <= level;
      pulse <= level & ~level_q;
    end
  end
endmodule

// ===== dv/slc_chk_assertions.sv
// Purpose: Port checks of slc_top
// Assumes: Bench keeps requests apart
// Notes: Bound from tb
`timescale 1ns/100ps
`include "slc_regs.vh"
module slc_chk (
  input wire clock, // Clock
  input wire rst, // Reset
  input wire key_load, // Load key
  input wire panel_sel_we, // Selector
  input wire remote_load_on, // Remote on
  input wire reg_rd, // Read strobe
  input wire [3:0] reg_addr, // Address
  input wire [31:0] reg_rdata, // Read data
  input wire load_on_q, // Load on
  input wire short_q, // Short
  input wire ext_short_q, // Ext short
  input wire lock_q, // Lock
  input wire [1:0] mode_q, // Mode
  input wire [15:0] setp_out_q // Setpoint
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Rising level of the load key
  sequence s_press;
    !key_load ##1 key_load;
  endsequence
  // Modes whose short means a maximum
  wire hi = mode_q == `SLC_MODE_CC || mode_q == `SLC_MODE_CP;
  AST_EXT: assert property (short_q |-> ext_short_q) else $error("ext short");
  AST_SHLD: assert property (short_q |-> load_on_q) else $error("short, load off");
  AST_SETP: assert property (short_q |-> setp_out_q == (hi ? 16'hFFFF : 16'h0000))
    else $error("short setpoint");
  AST_KON: assert property (s_press ##0 !(lock_q || short_q || load_on_q) |-> ##[1:3] load_on_q)
    else $error("load key on");
  AST_KOFF: assert property (s_press ##0 load_on_q |-> ##[1:3] !load_on_q)
    else $error("load key off");
  AST_REM: assert property (remote_load_on && !load_on_q |-> ##[1:2] load_on_q)
    else $error("remote on");
  AST_LOCK: assert property (lock_q && panel_sel_we |=> $stable(mode_q) [*2])
    else $error("locked mode change");
  AST_DROP: assert property ($fell(load_on_q) |-> !short_q && !ext_short_q)
    else $error("short kept");
  AST_RD0: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("idle rdata");
  AST_STAT: assert property (reg_rd && reg_addr == 4'h8 |=>
    reg_rdata == {29'h0, $past(lock_q), $past(short_q), $past(load_on_q)}) else $error("stat");
endmodule

// ===== dv/slc_panel.sv
// Purpose: Panel keys and remote/external load-on model
// Assumes: Debounced levels
// Notes: Released keys read low
`timescale 1ns/100ps
module slc_panel (
  input wire clock, // Clock
  output reg [5:0] keys = 6'h00 // Load,short,shift,clear,remote,ext
);
  // Levels change just after an edge
  task set(input int i, input bit v);
    @(posedge clock);
    keys[i] <= v;
  endtask
  // One-cycle press, then time to settle
  task push(input int i);
    set(i, 1'b1);
    @(posedge clock);
    keys[i] <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
endmodule

// ===== dv/tb.sv
// Purpose: Self-checking bench of slc_top
// Assumes: Keys come from the panel model
// Notes: Each scenario task checks its own results
`timescale 1ns/100ps
module tb;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg sel_we = 1'b0;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg [1:0] pm = 2'h0;
  reg [1:0] pr = 2'h0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wd = 32'h0;
  wire [31:0] rdata;
  wire [5:0] k;
  wire ld, sh, es, lk;
  wire [1:0] md;
  wire [1:0] rg;
  wire [15:0] sp;
  int n_fail = 0;
  int cmp_count = 0;
  // 20 MHz clock
  always #25 clock = ~clock;
  slc_panel i_slc_panel (.clock(clock), .keys(k));
  slc_top i_slc_top (.clock(clock), .rst(rst), .key_load(k[0]), .key_short(k[1]),
    .key_shift(k[2]), .key_clear(k[3]), .remote_load_on(k[4]), .ext_load_on(k[5]),
    .panel_sel_we(sel_we), .panel_mode(pm), .panel_range(pr), .panel_setp(16'h5A5A),
    .panel_setp_we(sel_we), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata(rdata), .load_on_q(ld), .short_q(sh), .ext_short_q(es), .lock_q(lk),
    .mode_q(md), .range_q(rg), .setp_out_q(sp));
  task chk(input string n, input [31:0] e, input [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus cycle; a read checks the data of the next cycle only
  task bus(input bit w, input [3:0] a, input [31:0] d);
    @(posedge clock);
    wr_s <= w;
    rd_s <= !w;
    addr <= a;
    wd <= d;
    @(posedge clock);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    if (!w) #1 chk("rdata", d, rdata);
  endtask
  // Lock, ext short, short, load after one more edge
  task st(input [3:0] e);
    @(posedge clock);
    #1 chk("state", e, {lk, es, sh, ld});
  endtask
  task pc(input int i, input [3:0] e);
    i_slc_panel.push(i);
    st(e);
  endtask
  task sel(input [1:0] m, input [1:0] r, input [3:0] e);
    @(posedge clock);
    sel_we <= 1'b1;
    pm <= m;
    pr <= r;
    @(posedge clock);
    sel_we <= 1'b0;
    st(e);
  endtask
  task t_basic;
    bus(0, 4'h4, 32'h13);
    bus(0, 4'h1, 32'h0);
    pc(0, 4'h1);
    bus(0, 4'h8, 32'h1);
    pc(0, 4'h0);
    pc(4, 4'h1);
    pc(0, 4'h0);
    pc(5, 4'h1);
    bus(1, 4'h0, 32'h1);
    st(4'h0);
  endtask
  task t_short;
    for (int m = 0; m < 4; m++) begin
      bus(1, 4'hC, {14'h0, m[1:0], 16'h1234});
      pc(1, 4'h7);
      chk("short setp", (m == 0 || m == 3) ? 16'hFFFF : 16'h0, sp);
      pc(1, 4'h0);
    end
    pc(0, 4'h1);
    bus(1, 4'h0, 32'h2);
    st(4'h7);
    pc(1, 4'h1);
    chk("restored setp", 16'h1234, sp);
    pc(0, 4'h0);
  endtask
  task t_cfg;
    bus(1, 4'h4, 32'h17);
    pc(1, 4'h0);
    pc(0, 4'h1);
    pc(1, 4'h7);
    pc(0, 4'h0);
    bus(1, 4'h4, 32'h03);
    pc(1, 4'h0);
    bus(1, 4'h4, 32'h07);
    bus(0, 4'h4, 32'h03);
    bus(1, 4'h4, 32'h1B);
    i_slc_panel.set(1, 1'b1);
    repeat (4) @(posedge clock);
    st(4'h7);
    i_slc_panel.set(1, 1'b0);
    repeat (3) @(posedge clock);
    st(4'h0);
    bus(1, 4'h4, 32'h13);
  endtask
  task t_mode;
    pc(0, 4'h1);
    sel(2'h1, 2'h0, 4'h0);
    bus(1, 4'h4, 32'h12);
    pc(0, 4'h1);
    sel(2'h2, 2'h0, 4'h1);
    sel(2'h2, 2'h1, 4'h0);
    chk("range", 32'h1, rg);
    bus(1, 4'h4, 32'h13);
    pc(1, 4'h7);
    sel(2'h0, 2'h1, 4'h0);
  endtask
  task t_lock;
    pc(4, 4'h1);
    pc(2, 4'h1);
    pc(3, 4'h9);
    sel(2'h3, 2'h3, 4'h9);
    chk("locked mode", 32'h0, md);
    pc(0, 4'h8);
    pc(0, 4'h8);
    pc(2, 4'h8);
    pc(3, 4'h0);
  endtask
  task conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (6000) @(posedge clock);
    n_fail++;
    conclude;
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_basic;
    t_short;
    t_cfg;
    t_mode;
    t_lock;
    conclude;
  end
endmodule
bind slc_top slc_chk i_slc_chk (.*);
